/* File: hdl/bms_boot_select.sv */
// Purpose: Decodes boot source from strap pins, drives chip select in EPROM mode
// Assumes: REF_CLK runs during reset; straps are static
// Notes: Mode is captured while RSTN is low and frozen after release
//
// What this block does
// - EPROM strap 1, link strap 0: boot EPROM, drive select pin as chip select.
// - Both straps 0 and select pin reads 1: boot from host.
// - EPROM 0, link 1, select pin 1: boot through link port.
// - All three low: no boot, execute from external memory.
`timescale 1ns/10ps
`default_nettype none
module bsl_boot_select
(
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic EPROM_BOOT_SELECT,
   input wire logic LINK_BOOT_SELECT,
   input wire logic BOOT_MEMORY_SELECT_I,
   input wire logic EPROM_CS_REQ,
   output logic BOOT_MEMORY_SELECT_O,
   output logic BOOT_MEMORY_SELECT_OE,
   output logic [2:0] BOOT_MODE,
   output logic MODE_VALID,
   output logic MODE_RESERVED
);
   // ****************************************
   // Strap synchronisation
   // ****************************************
   bsl_strap_if straps ();

   // Elaboration check on the shared synchroniser depth
   if (bsl_pkg::SYNC_STAGES < 2)
   begin : g_bad_sync
      $error("Strap synchroniser needs at least two stages");
   end

   // Synchroniser runs free during reset so the straps reach the decode
   bsl_sync
   #(
      .STAGES(bsl_pkg::SYNC_STAGES)
   )
   u_sync
   (
      .clk(REF_CLK),
      .pins({EPROM_BOOT_SELECT, LINK_BOOT_SELECT, BOOT_MEMORY_SELECT_I}),
      .straps(straps)
   );

   // ****************************************
   // Decode
   // ****************************************
   bsl_pkg::bsl_mode_t mode_d;
   bsl_pkg::bsl_mode_t mode_q;
   logic rst_sync1_q;
   logic in_reset_q;
   logic valid_q;
   logic mode_is_eprom;
   logic mode_is_rsvd;

   always_comb
   begin
      // Reserved combinations depend on the system
      unique case ({straps.eprom_boot_select, straps.link_boot_select,
                    straps.boot_memory_select})
         bsl_pkg::STRAPS_EPROM_PIN_LOW: mode_d = bsl_pkg::BSL_EPROM;
         bsl_pkg::STRAPS_EPROM_PIN_HIGH: mode_d = bsl_pkg::BSL_EPROM;
         bsl_pkg::STRAPS_HOST: mode_d = bsl_pkg::BSL_HOST;
         bsl_pkg::STRAPS_LINK: mode_d = bsl_pkg::BSL_LINK;
         bsl_pkg::STRAPS_NONE: mode_d = bsl_pkg::BSL_NONE;
         default: mode_d = bsl_pkg::BSL_RSVD;
      endcase
   end

   // Frozen mode split into the two cases that steer the pin and the flag
   always_comb
   begin
      mode_is_eprom = (mode_q == bsl_pkg::BSL_EPROM);
      mode_is_rsvd = (mode_q == bsl_pkg::BSL_RSVD);
   end

   // ****************************************
   // Reset tracking
   // ****************************************
   // Reset release seen through two flops so capture stops cleanly
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rst_sync1_q <= 1'b1;
         in_reset_q <= 1'b1;
      end
      else
      begin
         rst_sync1_q <= 1'b0;
         in_reset_q <= rst_sync1_q;
      end
   end

   // Mode tracks straps only while in reset, then holds
   always_ff @(posedge REF_CLK)
   begin
      if (in_reset_q)
      begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         valid_q <= 1'b0;
      end
      else if (in_reset_q)
      begin
         valid_q <= 1'b0;
      end
      else
      begin
         valid_q <= 1'b1;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Pin driven only in EPROM mode; input otherwise
   // Enable stays low in reset so the pin can be read as a strap
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         BOOT_MEMORY_SELECT_OE <= 1'b0;
      end
      else
      begin
         BOOT_MEMORY_SELECT_OE <= valid_q && mode_is_eprom;
      end
   end

   // Chip select follows the core request one cycle later
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         BOOT_MEMORY_SELECT_O <= bsl_pkg::CS_IDLE;
      end
      else if (valid_q && mode_is_eprom && EPROM_CS_REQ)
      begin
         BOOT_MEMORY_SELECT_O <= bsl_pkg::CS_ACTIVE;
      end
      else
      begin
         BOOT_MEMORY_SELECT_O <= bsl_pkg::CS_IDLE;
      end
   end

   // Mode reads as none until the capture window has closed
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         BOOT_MODE <= bsl_pkg::BSL_NONE;
      end
      else if (valid_q)
      begin
         BOOT_MODE <= mode_q;
      end
      else
      begin
         BOOT_MODE <= bsl_pkg::BSL_NONE;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         MODE_VALID <= 1'b0;
      end
      else
      begin
         MODE_VALID <= valid_q;
      end
   end

   // Reserved straps cannot be refused, only reported; pin stays an input
   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         MODE_RESERVED <= 1'b0;
      end
      else
      begin
         MODE_RESERVED <= valid_q && mode_is_rsvd;
      end
   end
endmodule : bsl_boot_select
`default_nettype wire

/* File: hdl/bms_pkg.sv */
// Purpose: Constants and types for the boot mode selector
// Assumes: Single core clock domain
// Notes: Encodings are internal to this block
package bsl_pkg;
   // ****************************************
   // Boot modes
   // ****************************************
   typedef enum logic [2:0]
   {
      BSL_NONE = 3'h0,
      BSL_HOST = 3'h1,
      BSL_LINK = 3'h3,
      BSL_EPROM = 3'h2,
      BSL_RSVD = 3'h6
   } bsl_mode_t;

   // Strap codes as {eprom, link, select pin}
   localparam logic [2:0] STRAPS_EPROM_PIN_LOW = 3'h4;
   localparam logic [2:0] STRAPS_EPROM_PIN_HIGH = 3'h5;
   localparam logic [2:0] STRAPS_HOST = 3'h1;
   localparam logic [2:0] STRAPS_LINK = 3'h3;
   localparam logic [2:0] STRAPS_NONE = 3'h0;

   // Synchroniser depth for strap pins
   localparam int unsigned SYNC_STAGES = 2;
   // Chip select active level when driving the pin in EPROM mode
   localparam logic CS_ACTIVE = 1'b0;
   localparam logic CS_IDLE = 1'b1;
endpackage : bsl_pkg

/* File: hdl/bms_strap_if.sv */
// Purpose: Carries synchronised strap levels between modules
// Assumes: Same clock on both ends
// Notes: None
`timescale 1ns/10ps
`default_nettype none
interface bsl_strap_if;
   logic eprom_boot_select;
   logic link_boot_select;
   logic boot_memory_select;
   modport src (output eprom_boot_select, output link_boot_select, output boot_memory_select);
   modport dst (input eprom_boot_select, input link_boot_select, input boot_memory_select);
endinterface : bsl_strap_if
`default_nettype wire

/* File: hdl/bms_sync.sv */
// Purpose: Two-flop synchroniser for the three strap pins
// Assumes: Pins are asynchronous to the clock
// Notes: First stage is read by the second stage only
`timescale 1ns/10ps
`default_nettype none
module bsl_sync
#(
   parameter int unsigned STAGES = bsl_pkg::SYNC_STAGES
)
(
   input wire logic clk,
   input wire logic [2:0] pins,
   bsl_strap_if.src straps
);
   logic [STAGES-1:0][2:0] chain_q;

   if (STAGES < 2)
   begin : g_bad_stages
      $error("Strap synchroniser needs at least two stages");
   end

   // No reset: the chain must keep tracking the straps while reset is held
   always_ff @(posedge clk)
   begin
      chain_q[0] <= pins;
      for (int i = 1; i < STAGES; i++)
      begin
         chain_q[i] <= chain_q[i-1];
      end
   end

   assign straps.eprom_boot_select = chain_q[STAGES-1][2];
   assign straps.link_boot_select = chain_q[STAGES-1][1];
   assign straps.boot_memory_select = chain_q[STAGES-1][0];
endmodule : bsl_sync
`default_nettype wire

/* File: test/bsl_asserts.sv */
// Purpose: Boot mode checks
// Assumes: Straps move only in reset
// Notes: Bound to the top
`timescale 1ns/10ps
`default_nettype none
module bsl_asserts
(
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic EPROM_BOOT_SELECT,
   input wire logic LINK_BOOT_SELECT,
   input wire logic BOOT_MEMORY_SELECT_I,
   input wire logic EPROM_CS_REQ,
   input wire logic BOOT_MEMORY_SELECT_O,
   input wire logic BOOT_MEMORY_SELECT_OE,
   input wire logic MODE_VALID,
   input wire logic MODE_RESERVED,
   input wire logic [2:0] BOOT_MODE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   chk_eprom_cs: assert property (EPROM_CS_REQ && BOOT_MEMORY_SELECT_OE
      |=> !BOOT_MEMORY_SELECT_O) else $error("no select");
   chk_host_none: assert property (MODE_VALID && !EPROM_BOOT_SELECT
      && !LINK_BOOT_SELECT |-> BOOT_MODE == {2'h0, BOOT_MEMORY_SELECT_I}) else $error("host");
   chk_link_boot: assert property (MODE_VALID && LINK_BOOT_SELECT
      && !EPROM_BOOT_SELECT && BOOT_MEMORY_SELECT_I |-> BOOT_MODE == bsl_pkg::BSL_LINK)
      else $error("link");
   chk_eprom_mode: assert property (MODE_VALID && EPROM_BOOT_SELECT
      && !LINK_BOOT_SELECT |-> BOOT_MODE == bsl_pkg::BSL_EPROM && BOOT_MEMORY_SELECT_OE)
      else $error("eprom");
   chk_pin_idle: assert property (!BOOT_MEMORY_SELECT_OE
      |-> BOOT_MEMORY_SELECT_O == bsl_pkg::CS_IDLE) else $error("idle");
   chk_rsvd_flag: assert property (MODE_VALID && !LINK_BOOT_SELECT
      |-> !MODE_RESERVED) else $error("reserved");
   chk_mode_frozen: assert property (MODE_VALID
      |=> MODE_VALID && $stable(BOOT_MODE)) else $error("moved");
   chk_valid_delay: assert property ($rose(RSTN) |-> ##[1:5] MODE_VALID)
      else $error("late");
endmodule : bsl_asserts
bind bsl_boot_select bsl_asserts chk (.*);
`default_nettype wire

/* File: test/bsl_partner.sv */
// Purpose: Boot source on the select pin
// Assumes: Host or link ties the level
// Notes: Device drive wins
`timescale 1ns/10ps
`default_nettype none
module bsl_partner
(
   input wire logic oe,
   input wire logic o,
   input wire logic lvl,
   output logic pin
);
   assign pin = oe ? o : lvl;
endmodule : bsl_partner
`default_nettype wire

/* File: test/boot_mode_select_tb.sv */
// Purpose: Random boot strap trials
// Assumes: Straps static out of reset
// Notes: Reserved straps unused
`timescale 1ns/10ps
`default_nettype none
module boot_mode_select_tb;
   logic clk = 1'b0, rstn = 1'b0, e = 1'b0, l = 1'b0, lvl = 1'b0, req = 1'b0;
   wire pin, o, oe, valid, rsvd;
   wire [2:0] mode;
   int errors = 0, check_count = 0, seed = 10189, t;
   always #5 clk = ~clk;
   bsl_boot_select dut (.REF_CLK(clk), .RSTN(rstn), .EPROM_BOOT_SELECT(e),
      .LINK_BOOT_SELECT(l), .BOOT_MEMORY_SELECT_I(pin), .EPROM_CS_REQ(req),
      .BOOT_MEMORY_SELECT_O(o), .BOOT_MEMORY_SELECT_OE(oe), .BOOT_MODE(mode),
      .MODE_VALID(valid), .MODE_RESERVED(rsvd));
   bsl_partner src (.oe(oe), .o(o), .lvl(lvl), .pin(pin));
   function automatic logic [2:0] want_mode(logic ee, ll, pp);
      return ee ? bsl_pkg::BSL_EPROM : (ll ? bsl_pkg::BSL_LINK
         : (pp ? bsl_pkg::BSL_HOST : bsl_pkg::BSL_NONE));
   endfunction : want_mode
   task automatic check(logic [2:0] seen, want);
      check_count++;
      if (seen !== want)
      begin
         errors++;
         $display("unexpected %0t %h %h", $time, seen, want);
      end
   endtask : check
   task automatic results();
      $display("%0d checks %0d errors", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   initial
   begin
      repeat (3000) @(posedge clk);
      errors++;
      results();
   end
   initial
   begin
      for (int i = 0; i < 40; i++)
      begin
         t = i < 4 ? i : $random(seed);
         @(posedge clk);
         rstn <= 1'b0;
         req <= 1'b0;
         e <= t[1:0] == 2'h2;
         l <= t[1:0] == 2'h3;
         lvl <= t[0];
         repeat (12) @(posedge clk);
         rstn <= 1'b1;
         // Valid lands on the fourth edge after release
         repeat (6) @(posedge clk);
         req <= 1'b1;
         repeat (2) @(posedge clk);
         #1;
         check(mode, want_mode(e, l, lvl));
         check({1'b0, oe, o}, {1'b0, e, !e});
         check({2'h0, valid}, 3'h1);
         check({2'h0, rsvd}, 3'h0);
         $display("trial %0d done", i);
      end
      results();
   end
endmodule : boot_mode_select_tb
`default_nettype wire
